/* File: verilog/pcxm_crossbar.sv */
`timescale 1ns/1ns
`include "pcxm_defines.svh"

module pcxm_crossbar
   import pcxm_pkg::*;
#(
   parameter pcxm_order_t PRIO_ORDER    = PCXM_DEFAULT_ORDER,
   parameter logic [3:0]  PINNED_PORTS  = 4'hf,
   parameter int          ROUTED_PORTS  = `PCXM_ROUTED_PORTS
)
(
   input  wire logic                 clock,
   input  wire logic                 reset_n,
   input  wire logic [7:0]           route_select_0,
   input  wire logic [7:0]           route_select_1,
   input  wire logic [7:0]           route_select_2,
   input  wire logic [7:0]           port0_driver_config,
   input  wire logic [7:0]           port1_driver_config,
   input  wire logic [7:0]           port2_driver_config,
   input  wire logic [7:0]           port3_driver_config,
   input  wire logic                 uart_mode0,
   input  wire logic [3:0]           port_write,
   input  wire logic [7:0]           port_write_data,
   output logic      [7:0]           port_zero,
   output logic      [7:0]           port_one,
   output logic      [7:0]           port_two,
   output logic      [7:0]           port_three,
   output logic      [7:0]           port_zero_latch,
   output logic      [7:0]           port_one_latch,
   output logic      [7:0]           port_two_latch,
   output logic      [7:0]           port_three_latch,
   input  wire logic [PCXM_NSIG-1:0] periph_out,
   input  wire logic [PCXM_NSIG-1:0] periph_drive,
   output logic      [PCXM_NSIG-1:0] periph_in,
   input  wire logic [31:0]          pin_in,
   output logic      [31:0]          pin_out,
   output logic      [31:0]          pin_oe,
   output logic      [31:0]          pin_pullup
);

   localparam int PW     = `PCXM_PORT_WIDTH;
   localparam int NPINS  = PW * `PCXM_PORT_COUNT;
   localparam int NROUTE = PW * ROUTED_PORTS;

   // ----------------------------------------
   // parameter checks
   // ----------------------------------------
   if (ROUTED_PORTS < 1 || ROUTED_PORTS > `PCXM_ROUTED_PORTS)
   begin : g_bad_ports
      $error("routed port count must be 1 to 3");
   end
   if (PRIO_ORDER[0] != PCXM_SDA || PRIO_ORDER[1] != PCXM_SCL)
   begin : g_bad_order
      $error("two-wire bus must head the priority order");
   end

   // ----------------------------------------
   // function selection decode
   // ----------------------------------------
   logic [PCXM_NSIG-1:0] selected;
   logic [2:0]           pca_count;
   logic                 xbar_enable;
   logic                 weak_pullup_disable;

   assign xbar_enable = route_select_2[`PCXM_SEL2_XBAR_EN];
   assign weak_pullup_disable = route_select_2[`PCXM_SEL2_PULLUP_OFF];
   assign pca_count   = route_select_0[`PCXM_SEL0_PCA_HI:`PCXM_SEL0_PCA_LO];

   always_comb
   begin
      selected = '0;
      // whole interfaces only, no partial buses
      selected[PCXM_SDA]  = route_select_0[`PCXM_SEL0_TWI];
      selected[PCXM_SCL]  = route_select_0[`PCXM_SEL0_TWI];
      selected[PCXM_SCK]  = route_select_0[`PCXM_SEL0_SPI];
      selected[PCXM_MISO] = route_select_0[`PCXM_SEL0_SPI];
      selected[PCXM_MOSI] = route_select_0[`PCXM_SEL0_SPI];
      selected[PCXM_NSS]  = route_select_0[`PCXM_SEL0_SPI];
      selected[PCXM_TX]   = route_select_0[`PCXM_SEL0_UART];
      selected[PCXM_RX]   = route_select_0[`PCXM_SEL0_UART];
      // reserved pca codes route nothing
      if (pca_count <= `PCXM_PCA_MAX)
      begin
         selected[PCXM_CEX0] = pca_count > 3'h0;
         selected[PCXM_CEX1] = pca_count > 3'h1;
         selected[PCXM_CEX2] = pca_count > 3'h2;
         selected[PCXM_CEX3] = pca_count > 3'h3;
         selected[PCXM_CEX4] = pca_count > 3'h4;
      end
      selected[PCXM_ECI]    = route_select_0[`PCXM_SEL0_ECI];
      selected[PCXM_CMP0]   = route_select_0[`PCXM_SEL0_CMP0];
      selected[PCXM_CMP1]   = route_select_1[`PCXM_SEL1_CMP1];
      selected[PCXM_T0]     = route_select_1[`PCXM_SEL1_T0];
      selected[PCXM_INT0]   = route_select_1[`PCXM_SEL1_INT0];
      selected[PCXM_T1]     = route_select_1[`PCXM_SEL1_T1];
      selected[PCXM_INT1]   = route_select_1[`PCXM_SEL1_INT1];
      selected[PCXM_T2]     = route_select_1[`PCXM_SEL1_T2];
      selected[PCXM_T2EX]   = route_select_1[`PCXM_SEL1_T2EX];
      selected[PCXM_SYSCLK] = route_select_1[`PCXM_SEL1_SYSCLK];
      selected[PCXM_CNVST]  = route_select_2[`PCXM_SEL2_CNVST];
   end

   // ----------------------------------------
   // priority packing
   // ----------------------------------------
   pcxm_sig_t            pin_sig      [NROUTE];
   logic [NROUTE-1:0]    pin_routed;
   logic [4:0]           sig_pin      [PCXM_NSIG];
   logic [PCXM_NSIG-1:0] sig_routed;
   pcxm_sig_t            next_pin_sig [NROUTE];
   logic [NROUTE-1:0]    next_pin_routed;
   logic [4:0]           next_sig_pin [PCXM_NSIG];
   logic [PCXM_NSIG-1:0] next_sig_routed;

   always_comb
   begin
      int slot;
      slot = 0;
      next_pin_routed = '0;
      next_sig_routed = '0;
      for (int p = 0; p < NROUTE; p++)
      begin
         next_pin_sig[p] = PCXM_SDA;
      end
      for (int s = 0; s < PCXM_NSIG; s++)
      begin
         next_sig_pin[s] = 5'h00;
      end
      // walk in priority order; skipped functions leave no hole
      for (int i = 0; i < PCXM_NSIG; i++)
      begin
         if (selected[PRIO_ORDER[i]] && slot < NROUTE)
         begin
            next_pin_sig[slot]                 = PRIO_ORDER[i];
            next_pin_routed[slot]              = 1'h1;
            next_sig_pin[int'(PRIO_ORDER[i])]  = 5'(slot);
            next_sig_routed[int'(PRIO_ORDER[i])] = 1'h1;
            slot = slot + 1;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_routed <= '0;
         sig_routed <= '0;
         for (int p = 0; p < NROUTE; p++)
         begin
            pin_sig[p] <= PCXM_SDA;
         end
         for (int s = 0; s < PCXM_NSIG; s++)
         begin
            sig_pin[s] <= 5'h00;
         end
      end
      else
      begin
         pin_routed <= next_pin_routed;
         sig_routed <= next_sig_routed;
         pin_sig    <= next_pin_sig;
         sig_pin    <= next_sig_pin;
      end
   end

   // ----------------------------------------
   // port latches and pin reads
   // ----------------------------------------
   logic [7:0] latch          [`PCXM_PORT_COUNT];
   logic [7:0] next_latch     [`PCXM_PORT_COUNT];
   logic [7:0] pin_read       [`PCXM_PORT_COUNT];
   logic [7:0] next_pin_read  [`PCXM_PORT_COUNT];
   logic [PCXM_NSIG-1:0] next_periph_in;

   always_comb
   begin
      for (int k = 0; k < `PCXM_PORT_COUNT; k++)
      begin
         next_latch[k]    = port_write[k] ? port_write_data : latch[k];
         next_pin_read[k] = pin_in[k*PW +: PW];
      end
      // unrouted inputs idle high
      for (int s = 0; s < PCXM_NSIG; s++)
      begin
         next_periph_in[s] = (sig_routed[s] && xbar_enable) ?
                             pin_in[sig_pin[s]] : 1'h1;
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int k = 0; k < `PCXM_PORT_COUNT; k++)
         begin
            latch[k]    <= `PCXM_LATCH_RESET;
            pin_read[k] <= `PCXM_READ_RESET;
         end
         periph_in <= {PCXM_NSIG{`PCXM_PERIPH_IN_RESET}};
      end
      else
      begin
         latch     <= next_latch;
         pin_read  <= next_pin_read;
         periph_in <= next_periph_in;
      end
   end

   assign port_zero        = pin_read[0];
   assign port_one         = pin_read[1];
   assign port_two         = pin_read[2];
   assign port_three       = pin_read[3];
   assign port_zero_latch  = latch[0];
   assign port_one_latch   = latch[1];
   assign port_two_latch   = latch[2];
   assign port_three_latch = latch[3];

   // ----------------------------------------
   // pin cells
   // ----------------------------------------
   logic [31:0] config_bits;
   assign config_bits = {port3_driver_config, port2_driver_config,
                         port1_driver_config, port0_driver_config};

   for (genvar g = 0; g < NPINS; g++)
   begin : g_pin
      logic routed;
      logic fval;
      logic fdrv;
      logic force_od;
      if (g < NROUTE)
      begin : g_route
         assign routed   = pin_routed[g];
         assign fval     = periph_out[pin_sig[g]];
         assign fdrv     = periph_drive[pin_sig[g]];
         // a disabled crossbar leaves every pin an undriven input, so no forced open-drain
         assign force_od = xbar_enable && pin_routed[g] &&
                           (pin_sig[g] == PCXM_SDA || pin_sig[g] == PCXM_SCL ||
                            (pin_sig[g] == PCXM_RX && uart_mode0));
      end
      else
      begin : g_gpio
         // port 3 never carries a function
         assign routed   = 1'h0;
         assign fval     = 1'h1;
         assign fdrv     = 1'h0;
         assign force_od = 1'h0;
      end
      pcxm_pin_cell u_cell
      (
         .clock               (clock),
         .reset_n             (reset_n),
         .xbar_enable         (xbar_enable),
         .present             (PINNED_PORTS[g/PW]),
         .routed              (routed),
         .func_value          (fval),
         .func_drive          (fdrv),
         .latch_bit           (latch[g/PW][g%PW]),
         .push_pull           (config_bits[g]),
         .force_open_drain    (force_od),
         .weak_pullup_disable (weak_pullup_disable),
         .pin_out             (pin_out[g]),
         .pin_oe              (pin_oe[g]),
         .pin_pullup          (pin_pullup[g])
      );
   end

endmodule

/* File: include/pcxm_defines.svh */
// Behaviour
// - every function has fixed priority; two-wire bus first, on port 0 bits 0-1
// - functions pack from lsb upward, port 0, then port 1, then port 2
// - unselected functions take no pin; later functions move up
// - bus interfaces route all their signals together, never a subset
// - unclaimed pins stay general-purpose, one contiguous run after functions
// - only ports 0-2 are routable; port 3 is always general-purpose
// - three selection registers choose functions; unselected pins stay port I/O
// - crossbar enable bit set to 1 activates routing
// - crossbar disabled makes every pin a general-purpose input
// - per-pin open-drain or push-pull choice, also for routed functions
// - two-wire data/clock and uart receive in mode 0 are always open-drain
// - pull-up disable at 0 enables weak pull-ups on open-drain pins only
// - open-drain pin driving low has its weak pull-up off
// - port reads return actual pin levels, even on routed pins
// - functions on absent pins still use slots but connect nowhere, except that their inputs still read pin_in
// - driver config bit 0 means open-drain, 1 means push-pull
// - read-modify-write reads the port latch, not the pins
`ifndef PCXM_DEFINES_SVH
`define PCXM_DEFINES_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define PCXM_PORT_WIDTH      8
`define PCXM_PORT_COUNT      4
`define PCXM_ROUTED_PORTS    3

// ----------------------------------------
// route_select_0 fields
// ----------------------------------------
`define PCXM_SEL0_TWI        0
`define PCXM_SEL0_SPI        1
`define PCXM_SEL0_UART       2
`define PCXM_SEL0_PCA_LO     3
`define PCXM_SEL0_PCA_HI     5
`define PCXM_SEL0_ECI        6
`define PCXM_SEL0_CMP0       7
`define PCXM_PCA_MAX         3'h5

// ----------------------------------------
// route_select_1 fields
// ----------------------------------------
`define PCXM_SEL1_CMP1       0
`define PCXM_SEL1_T0         1
`define PCXM_SEL1_INT0       2
`define PCXM_SEL1_T1         3
`define PCXM_SEL1_INT1       4
`define PCXM_SEL1_T2         5
`define PCXM_SEL1_T2EX       6
`define PCXM_SEL1_SYSCLK     7

// ----------------------------------------
// route_select_2 fields
// ----------------------------------------
`define PCXM_SEL2_CNVST      0
`define PCXM_SEL2_XBAR_EN    6
`define PCXM_SEL2_PULLUP_OFF 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define PCXM_LATCH_RESET     8'hff
`define PCXM_PIN_OUT_RESET   1'h0
`define PCXM_PIN_OE_RESET    1'h0
`define PCXM_PULLUP_RESET    1'h1
`define PCXM_READ_RESET      8'hff
`define PCXM_PERIPH_IN_RESET 1'h1

`endif

/* File: include/pcxm_pkg.sv */
package pcxm_pkg;

   // ----------------------------------------
   // peripheral signal codes
   // ----------------------------------------
   typedef enum logic [4:0] {
      PCXM_SDA    = 5'h00,
      PCXM_SCL    = 5'h01,
      PCXM_SCK    = 5'h02,
      PCXM_MISO   = 5'h03,
      PCXM_MOSI   = 5'h04,
      PCXM_NSS    = 5'h05,
      PCXM_TX     = 5'h06,
      PCXM_RX     = 5'h07,
      PCXM_CEX0   = 5'h08,
      PCXM_CEX1   = 5'h09,
      PCXM_CEX2   = 5'h0a,
      PCXM_CEX3   = 5'h0b,
      PCXM_CEX4   = 5'h0c,
      PCXM_ECI    = 5'h0d,
      PCXM_CMP0   = 5'h0e,
      PCXM_T0     = 5'h0f,
      PCXM_INT0   = 5'h10,
      PCXM_T1     = 5'h11,
      PCXM_INT1   = 5'h12,
      PCXM_T2     = 5'h13,
      PCXM_T2EX   = 5'h14,
      PCXM_CMP1   = 5'h15,
      PCXM_SYSCLK = 5'h16,
      PCXM_CNVST  = 5'h17
   } pcxm_sig_t;

   localparam int PCXM_NSIG = 24;

   typedef pcxm_sig_t pcxm_order_t [PCXM_NSIG];

   localparam pcxm_order_t PCXM_DEFAULT_ORDER = '{
      PCXM_SDA, PCXM_SCL, PCXM_SCK, PCXM_MISO, PCXM_MOSI, PCXM_NSS,
      PCXM_TX, PCXM_RX, PCXM_CEX0, PCXM_CEX1, PCXM_CEX2, PCXM_CEX3,
      PCXM_CEX4, PCXM_ECI, PCXM_CMP0, PCXM_T0, PCXM_INT0, PCXM_T1,
      PCXM_INT1, PCXM_T2, PCXM_T2EX, PCXM_CMP1, PCXM_SYSCLK, PCXM_CNVST
   };

endpackage

/* File: verilog/pcxm_pin_cell.sv */
`timescale 1ns/1ns
`include "pcxm_defines.svh"

module pcxm_pin_cell
(
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic xbar_enable,
   input  wire logic present,
   input  wire logic routed,
   input  wire logic func_value,
   input  wire logic func_drive,
   input  wire logic latch_bit,
   input  wire logic push_pull,
   input  wire logic force_open_drain,
   input  wire logic weak_pullup_disable,
   output logic      pin_out,
   output logic      pin_oe,
   output logic      pin_pullup
);

   logic next_pin_out;
   logic next_pin_oe;
   logic next_pin_pullup;
   logic value;
   logic drive_wanted;
   logic open_drain;

   always_comb
   begin
      value        = routed ? func_value : latch_bit;
      drive_wanted = routed ? func_drive : 1'h1;
      open_drain   = force_open_drain | ~push_pull;
      next_pin_out    = 1'h0;
      next_pin_oe     = 1'h0;
      next_pin_pullup = open_drain & ~weak_pullup_disable;
      if (!present)
      begin
         // absent pin: nothing leaves the die
         next_pin_pullup = 1'h0;
      end
      else if (!xbar_enable)
      begin
         next_pin_oe = 1'h0;
      end
      else if (open_drain)
      begin
         next_pin_oe = drive_wanted & ~value;
         if (drive_wanted && !value)
         begin
            next_pin_pullup = 1'h0;
         end
      end
      else
      begin
         next_pin_out = value;
         next_pin_oe  = drive_wanted;
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_out    <= `PCXM_PIN_OUT_RESET;
         pin_oe     <= `PCXM_PIN_OE_RESET;
         pin_pullup <= `PCXM_PULLUP_RESET;
      end
      else
      begin
         pin_out    <= next_pin_out;
         pin_oe     <= next_pin_oe;
         pin_pullup <= next_pin_pullup;
      end
   end

endmodule

/* File: test/pcxm_crossbar_asserts.sv */
`timescale 1ns/1ns
module pcxm_crossbar_asserts
   import pcxm_pkg::*;
#(
   parameter logic [3:0] PINNED_PORTS = 4'hf
)
(
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic [7:0]  route_select_0,
   input wire logic [7:0]  route_select_1,
   input wire logic [7:0]  route_select_2,
   input wire logic [7:0]  port0_driver_config,
   input wire logic [7:0]  port1_driver_config,
   input wire logic [7:0]  port3_driver_config,
   input wire logic        uart_mode0,
   input wire logic [3:0]  port_write,
   input wire logic [7:0]  port_write_data,
   input wire logic [7:0]  port_zero,
   input wire logic [7:0]  port_one,
   input wire logic [7:0]  port_two,
   input wire logic [7:0]  port_three,
   input wire logic [7:0]  port_zero_latch,
   input wire logic [7:0]  port_one_latch,
   input wire logic [7:0]  port_three_latch,
   input wire logic [23:0] periph_out,
   input wire logic [23:0] periph_drive,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] pin_pullup
);
   // ----
   // settle tracker
   // ----
   // pin controls lag the selects by two edges; judge only quiet stretches
   logic [96:0] snap;
   logic [96:0] prev;
   logic [96:0] next_prev;
   logic [1:0]  quiet;
   logic [1:0]  next_quiet;
   logic        settled;
   logic        en;
   assign snap = {route_select_0, route_select_1, route_select_2, port0_driver_config,
                  port1_driver_config, port3_driver_config, uart_mode0, periph_out,
                  periph_drive};
   assign en = route_select_2[6];
   assign settled = quiet == 2'h3 && snap == prev && port_write == 4'h0;
   always_comb
   begin
      next_prev = snap;
      next_quiet = quiet;
      if (snap != prev || port_write != 4'h0)
         next_quiet = 2'h0;
      else if (quiet != 2'h3)
         next_quiet = quiet + 2'h1;
   end
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prev  <= '0;
         quiet <= 2'h0;
      end
      else
      begin
         prev  <= next_prev;
         quiet <= next_quiet;
      end
   end
   // ----
   // properties
   // ----
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   sequence s_off;
      settled && !en;
   endsequence
   sequence s_twi;
      settled && en && route_select_0[0];
   endsequence
   chk_off_no_drive: assert property (s_off |-> pin_oe == 32'h0)
      else $error("pin driven while crossbar off");
   chk_twi_open_drain: assert property (s_twi |-> pin_out[1:0] == 2'h0
      && pin_oe[1:0] == (periph_drive[1:0] & ~periph_out[1:0]))
      else $error("two-wire pins not open-drain on bits 0 and 1");
   chk_pullup_low_off: assert property ((pin_oe & ~pin_out & pin_pullup) == 32'h0)
      else $error("pull-up on while driving low");
   chk_weak_all_off: assert property (settled && route_select_2[7] |-> pin_pullup == 32'h0)
      else $error("pull-up on while disabled");
   chk_port3_gpio: assert property (settled && en && PINNED_PORTS[3] |->
      pin_oe[31:24] == (port3_driver_config | ~port_three_latch)
      && pin_out[31:24] == (port3_driver_config & port_three_latch))
      else $error("port three not plain port");
   chk_port3_pullup: assert property (settled && !route_select_2[7] && PINNED_PORTS[3] |->
      pin_pullup[31:24] == (~port3_driver_config & (en ? port_three_latch : 8'hff)))
      else $error("port three pull-up wrong");
   chk_absent_quiet: assert property (settled && !PINNED_PORTS[2] |->
      pin_oe[23:16] == 8'h0 && pin_pullup[23:16] == 8'h0)
      else $error("absent port drives");
   chk_gpio_unrouted: assert property (settled && en && route_select_0 == 8'h0
      && route_select_1 == 8'h0 && !route_select_2[0] |-> pin_oe[15:0] ==
      ({port1_driver_config, port0_driver_config} | ~{port_one_latch, port_zero_latch}))
      else $error("unrouted pin not plain port");
   chk_read_pins: assert property ($past(reset_n) |->
      {port_three, port_two, port_one, port_zero} == $past(pin_in))
      else $error("port read not pin level");
   chk_latch_take: assert property (port_write[0] |=>
      port_zero_latch == $past(port_write_data))
      else $error("port latch missed write");
endmodule
bind pcxm_crossbar pcxm_crossbar_asserts #(.PINNED_PORTS(PINNED_PORTS)) u_chk
(
   .clock(clock), .reset_n(reset_n), .route_select_0(route_select_0),
   .route_select_1(route_select_1), .route_select_2(route_select_2),
   .port0_driver_config(port0_driver_config), .port1_driver_config(port1_driver_config),
   .port3_driver_config(port3_driver_config), .uart_mode0(uart_mode0),
   .port_write(port_write), .port_write_data(port_write_data), .port_zero(port_zero),
   .port_one(port_one), .port_zero_latch(port_zero_latch), .port_one_latch(port_one_latch),
   .port_two(port_two), .port_three(port_three),
   .port_three_latch(port_three_latch), .periph_out(periph_out),
   .periph_drive(periph_drive), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .pin_pullup(pin_pullup)
);

/* File: test/pcxm_pad_model.sv */
`timescale 1ns/1ns
module pcxm_pad_model
(
   input  wire logic        clock,
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   input  wire logic [31:0] pin_pullup,
   input  wire logic [31:0] ext_en,
   input  wire logic [31:0] ext_val,
   output logic      [31:0] pin_in
);
   // a floating pad shows the inverse of its last level, never a stale one
   logic [31:0] drift = 32'h0;
   always_ff @(posedge clock)
      drift <= ~pin_in;
   assign pin_in = (pin_oe & pin_out)
                 | (~pin_oe & ((ext_en & ext_val) | (~ext_en & (pin_pullup | drift))));
endmodule

/* File: test/test_priority_crossbar_port_mux.sv */
`timescale 1ns/1ns
module test_priority_crossbar_port_mux
   import pcxm_pkg::*;
();
   // port two is not pinned out
   localparam logic [3:0] PINNED = 4'hb;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  route_select_0 = 8'h0;
   logic [7:0]  route_select_1 = 8'h0;
   logic [7:0]  route_select_2 = 8'h0;
   logic [7:0]  cfg [4] = '{default: 8'hff};
   logic        uart_mode0 = 1'b0;
   logic [3:0]  port_write = 4'h0;
   logic [7:0]  port_write_data = 8'h0;
   logic [23:0] periph_out = 24'h0;
   logic [23:0] periph_drive = 24'h0;
   logic [31:0] ext_val = 32'h5a00c396;
   logic [7:0]  exp_latch [4] = '{default: 8'hff};
   logic [7:0]  port_zero, port_one, port_two, port_three;
   logic [7:0]  latch [4];
   logic [23:0] periph_in;
   logic [31:0] pin_in, pin_out, pin_oe, pin_pullup;
   int          n_errors = 0;
   int          n_checks = 0;
   int          cycles = 0;

   pcxm_crossbar #(.PINNED_PORTS(PINNED)) u_dut
   (
      .clock(clock), .reset_n(reset_n), .route_select_0(route_select_0),
      .route_select_1(route_select_1), .route_select_2(route_select_2),
      .port0_driver_config(cfg[0]), .port1_driver_config(cfg[1]),
      .port2_driver_config(cfg[2]), .port3_driver_config(cfg[3]), .uart_mode0(uart_mode0),
      .port_write(port_write), .port_write_data(port_write_data), .port_zero(port_zero),
      .port_one(port_one), .port_two(port_two), .port_three(port_three),
      .port_zero_latch(latch[0]), .port_one_latch(latch[1]), .port_two_latch(latch[2]),
      .port_three_latch(latch[3]), .periph_out(periph_out), .periph_drive(periph_drive),
      .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pullup)
   );
   pcxm_pad_model u_pads
   (
      .clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .ext_en(32'hff00ffff), .ext_val(ext_val), .pin_in(pin_in)
   );

   always #10 clock = ~clock;

   // ----
   // helpers
   // ----
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic compare(logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apply(logic [7:0] s0, logic [7:0] s1, logic [7:0] s2);
      @(posedge clock);
      route_select_0 <= s0;
      route_select_1 <= s1;
      route_select_2 <= s2;
      // five edges so the checker's settle window opens before judging
      repeat (5) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic write_port(logic [3:0] which, logic [7:0] data);
      @(posedge clock);
      port_write <= which;
      port_write_data <= data;
      for (int k = 0; k < 4; k++)
         if (which[k])
            exp_latch[k] = data;
   endtask
   // expected pads from the selects, packed in priority order
   task automatic check_all();
      pcxm_sig_t   map [24];
      pcxm_sig_t   s;
      logic [23:0] pick, e_in, mask;
      logic [31:0] e_oe, e_out, e_pu, lvl;
      logic        rt, pp, val, drv;
      logic [2:0]  pca;
      int          n;
      int          k;
      pca = route_select_0[5:3];
      pick = {route_select_2[0], route_select_1[7], route_select_1[0], route_select_1[6:1],
              route_select_0[7:6], 5'h1f >> (3'h5 - pca), {2{route_select_0[2]}},
              {4{route_select_0[1]}}, {2{route_select_0[0]}}};
      n = 0;
      e_in = '1;
      mask = '1;
      map = '{default: PCXM_SDA};
      for (int i = 0; i < PCXM_NSIG; i++)
      begin
         s = PCXM_DEFAULT_ORDER[i];
         if (pick[s])
         begin
            map[n] = s;
            n++;
         end
      end
      for (int p = 0; p < 32; p++)
      begin
         k = p / 8;
         s = map[p % 24];
         rt = route_select_2[6] && p < n;
         drv = rt ? periph_drive[s] : 1'b1;
         val = rt ? periph_out[s] : exp_latch[k][p % 8];
         pp = cfg[k][p % 8] && !(rt && (s == PCXM_SDA || s == PCXM_SCL
              || (s == PCXM_RX && uart_mode0)));
         e_oe[p] = route_select_2[6] && PINNED[k] && drv && (pp || !val);
         e_out[p] = pp && val;
         e_pu[p] = PINNED[k] && !route_select_2[7] && !pp && !e_oe[p];
         lvl[p] = e_oe[p] ? e_out[p] : ext_val[p];
         if (rt)
         begin
            e_in[s] = lvl[p];
            mask[s] = PINNED[k];
         end
      end
      compare(pin_oe, e_oe);
      compare(pin_out & e_oe, e_out & e_oe);
      compare(pin_pullup, e_pu);
      compare({8'h0, periph_in & mask}, {8'h0, e_in & mask});
      compare({port_three, 8'h0, port_one, port_zero}, lvl & 32'hff00ffff);
   endtask

   // ----
   // scenarios
   // ----
   task automatic t_disabled();
      @(posedge clock);
      periph_drive <= 24'hffffff;
      apply(8'hff, 8'hff, 8'h81);
      check_all();
      $display("disabled done");
   endtask
   task automatic t_twi();
      @(posedge clock);
      periph_out <= 24'h000002;
      apply(8'h01, 8'h00, 8'h40);
      check_all();
      $display("two-wire done");
   endtask
   task automatic t_pack();
      @(posedge clock);
      periph_out <= 24'ha5c3f0;
      periph_drive <= 24'h3f0f3d;
      apply(8'h16, 8'h81, 8'h40);
      check_all();
      for (int i = 0; i < 8; i++)
      begin
         apply({2'h0, 3'(i), 3'h5}, 8'h00, 8'h40);
         check_all();
      end
      apply(8'hef, 8'hff, 8'h41);
      check_all();
      $display("packing done");
   endtask
   task automatic t_modes();
      @(posedge clock);
      cfg <= '{8'h5a, 8'h0f, 8'h33, 8'h96};
      periph_out <= 24'hffffff;
      periph_drive <= 24'hffffff;
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clock);
         uart_mode0 <= m[0];
         apply(8'h04, 8'h00, {m[1], 7'h40});
         check_all();
      end
      $display("driver modes done");
   endtask
   task automatic t_latch();
      write_port(4'h1, 8'h0f);
      write_port(4'h8, 8'h3c);
      @(posedge clock);
      port_write <= 4'h0;
      apply(8'h00, 8'h00, 8'h40);
      for (int k = 0; k < 4; k++)
         compare(32'(latch[k]), 32'(exp_latch[k]));
      check_all();
      $display("latch done");
   endtask

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         n_errors++;
         close_out();
      end
   end

   initial
   begin
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      t_disabled();
      t_twi();
      t_pack();
      t_modes();
      t_latch();
      close_out();
   end
endmodule
